// *** rtl/sdcmd_pkg.sv ***
// Package: constants and types for the SDRAM command interface
`default_nettype none
package sdcmd_pkg;
	localparam int ROW_W = 12;
	localparam int COL_W = 8;
	localparam int BANKS = 4;
	localparam int DQ_W = 32;
	localparam int MASK_W = 4;
	localparam int AP_BIT = 10;
	localparam int CLK_MHZ = 50;
	// Read mask-to-high-Z latency in clocks
	localparam int MASK_RD_LAT = 2;
	// Self refresh exit minimum in clocks
	localparam int SR_EXIT_CLKS = 2;
	// Internal self refresh interval, 15625 ns per row
	localparam int SR_INTERVAL_NS = 15625;
	localparam int SR_INTERVAL_CYC = SR_INTERVAL_NS * CLK_MHZ / 1000;
	localparam int SR_CNT_W = 10;
	localparam logic [11:0] MODE_RESET = 12'h000;
	localparam logic [11:0] REFRESH_ROW_RESET = 12'h000;
	localparam logic [2:0] BURST_LEN_FIELD_MSB = 3'h2;
	localparam int FIFO_DEPTH = 16;
	typedef enum logic [2:0] {
		SDCMD_NOP = 3'b000,
		SDCMD_ACT = 3'b001,
		SDCMD_RD = 3'b010,
		SDCMD_WR = 3'b011,
		SDCMD_BST = 3'b100,
		SDCMD_PRE = 3'b101,
		SDCMD_REF = 3'b110,
		SDCMD_MRS = 3'b111
	} sdcmd_cmd_t;
	typedef enum logic [1:0] {
		SDCMD_IDLE = 2'b00,
		SDCMD_BURST_RD = 2'b01,
		SDCMD_BURST_WR = 2'b10,
		SDCMD_SELFREF = 2'b11
	} sdcmd_state_t;
endpackage
`default_nettype wire

// *** rtl/sdcmd_fifo.sv ***
// Synchronous FIFO with registered read data
`timescale 1ns/10ps
`default_nettype none
module sdcmd_fifo #(
	parameter int WIDTH = 32,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0] wptr, rptr, next_wptr, next_rptr;
	logic do_wr, do_rd, next_out_valid;
	// ==========================================
	// Pointers
	always_comb
	begin
		in_ready = (wptr - rptr) != (AW+1)'(DEPTH);
		do_wr = in_valid && in_ready;
		do_rd = out_valid && out_ready;
		next_wptr = do_wr ? wptr + 1'b1 : wptr;
		next_rptr = do_rd ? rptr + 1'b1 : rptr;
		next_out_valid = next_wptr != next_rptr;
	end
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wptr <= '0;
			rptr <= '0;
			out_valid <= 1'b0;
		end
		else
		begin
			wptr <= next_wptr;
			rptr <= next_rptr;
			out_valid <= next_out_valid;
		end
	end
	always_ff @(posedge clk)
	begin
		if (do_wr)
			mem[wptr[AW-1:0]] <= in_data;
	end
	// Data is shown before the pop so out_data stays registered
	// A word written into an empty FIFO bypasses the memory
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
			out_data <= '0;
		else if (do_wr && next_rptr == wptr)
			out_data <= in_data;
		else
			out_data <= mem[next_rptr[AW-1:0]];
	end
endmodule
`default_nettype wire

// *** rtl/sdcmd_core.sv ***
// Command decoder and bank sequencer of the SDRAM device
//
// Summary of operation
// - All inputs but sys_rst sampled on rising clock only
// - Chip select high blocks new commands
// - Decode strobes into eight commands
// - Refresh with clock gate low enters self refresh
// - Address bit ten selects one-shot auto precharge
// - Precharge all when bit ten high
// - Mode load takes opcode from address
// - Auto precharge closes row after burst
// - Read mask high floats lane two clocks later
// - Write mask blocks lane storage immediately
// - Burst terminate stops the latest burst
// - Refresh rows come from internal counter
// - Self refresh ignores all but clock gate
`timescale 1ns/10ps
`default_nettype none
module sdcmd_core (
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Command pins, active low strobes
	input wire logic chip_sel_n,
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_strobe_n,
	input wire logic clk_gate,
	input wire logic [1:0] bank_sel,
	input wire logic [11:0] addr,
	input wire logic [3:0] data_mask,
	// Data pins
	input wire logic [31:0] dq_in,
	output logic [31:0] dq_out,
	output logic [3:0] dq_oe,
	// Array side: write stream through FIFO, read data back
	output logic arr_wr_valid,
	input wire logic arr_wr_ready,
	output logic [57:0] arr_wr_data,
	input wire logic [31:0] arr_rd_data,
	output logic [11:0] arr_rd_row,
	output logic [7:0] arr_rd_col,
	output logic [1:0] arr_rd_bank,
	// Status
	output logic [3:0] bank_open,
	output logic [11:0] mode_reg,
	output logic [11:0] refresh_row,
	output logic self_refresh,
	output logic refresh_pulse,
	output logic wr_stall
);
	// ==========================================
	// Input synchronisers
	logic [54:0] pin_s1, pin_s2;
	logic cs_n, ras_n, cas_n, we_n, cke;
	logic [1:0] ba;
	logic [11:0] a;
	logic [3:0] dqm;
	logic [31:0] dqi;
	// Pins cross from the pad domain; two stages before use
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			pin_s1 <= {1'b1, 54'h0};
			pin_s2 <= {1'b1, 54'h0};
		end
		else
		begin
			pin_s1 <= {chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n,
				clk_gate, bank_sel, addr, data_mask, dq_in};
			pin_s2 <= pin_s1;
		end
	end
	assign {cs_n, ras_n, cas_n, we_n, cke, ba, a, dqm, dqi} = pin_s2;

	// ==========================================
	// Command decode
	function automatic sdcmd_pkg::sdcmd_cmd_t decode(input logic c,
		input logic r, input logic k, input logic w);
		sdcmd_pkg::sdcmd_cmd_t d;
		d = sdcmd_pkg::SDCMD_NOP;
		if (!c)
		begin
			case ({r, k, w})
				3'b011: d = sdcmd_pkg::SDCMD_ACT;
				3'b101: d = sdcmd_pkg::SDCMD_RD;
				3'b100: d = sdcmd_pkg::SDCMD_WR;
				3'b110: d = sdcmd_pkg::SDCMD_BST;
				3'b010: d = sdcmd_pkg::SDCMD_PRE;
				3'b001: d = sdcmd_pkg::SDCMD_REF;
				3'b000: d = sdcmd_pkg::SDCMD_MRS;
				default: d = sdcmd_pkg::SDCMD_NOP;
			endcase
		end
		return d;
	endfunction
	sdcmd_pkg::sdcmd_cmd_t cmd;
	assign cmd = decode(cs_n, ras_n, cas_n, we_n);

	// ==========================================
	// State
	sdcmd_pkg::sdcmd_state_t state, next_state;
	logic [3:0] next_bank_open;
	logic [11:0] open_row [4];
	logic [11:0] next_open_row [4];
	logic [11:0] next_mode_reg, next_refresh_row;
	logic [7:0] col, next_col;
	logic [1:0] cur_bank, next_cur_bank;
	logic ap, next_ap;
	logic [3:0] beat, next_beat;
	logic [sdcmd_pkg::SR_CNT_W-1:0] sr_cnt, next_sr_cnt;
	logic [3:0] rd_en_pipe, next_rd_en_pipe;
	logic [3:0] mask_d1, next_mask_d1;
	logic next_refresh_pulse, next_self_refresh;
	logic [3:0] burst_len;
	logic burst_full, fifo_in_ready, wr_push;

	// Mode field 2:0 gives burst length; 7 is full page
	always_comb
	begin
		burst_full = mode_reg[2:0] == 3'h7;
		case (mode_reg[2:0])
			3'h0: burst_len = 4'h1;
			3'h1: burst_len = 4'h2;
			3'h2: burst_len = 4'h4;
			default: burst_len = 4'h8;
		endcase
	end

	always_comb
	begin
		next_state = state;
		next_bank_open = bank_open;
		next_open_row = open_row;
		next_mode_reg = mode_reg;
		next_refresh_row = refresh_row;
		next_col = col;
		next_cur_bank = cur_bank;
		next_ap = ap;
		next_beat = beat;
		next_sr_cnt = sr_cnt;
		next_refresh_pulse = 1'b0;
		next_self_refresh = self_refresh;
		wr_push = 1'b0;
		if (state == sdcmd_pkg::SDCMD_SELFREF)
		begin
			// Only clock gate is looked at here
			next_sr_cnt = sr_cnt + 1'b1;
			if (sr_cnt == sdcmd_pkg::SR_CNT_W'(
				sdcmd_pkg::SR_INTERVAL_CYC % 1024))
			begin
				next_sr_cnt = '0;
				next_refresh_row = refresh_row + 1'b1;
				next_refresh_pulse = 1'b1;
			end
			if (cke)
			begin
				next_state = sdcmd_pkg::SDCMD_IDLE;
				next_self_refresh = 1'b0;
			end
		end
		else
		begin
			// Bursts advance each clock
			if (state != sdcmd_pkg::SDCMD_IDLE)
			begin
				if (state == sdcmd_pkg::SDCMD_BURST_WR)
					wr_push = !dqm[0] || !dqm[1] || !dqm[2] || !dqm[3];
				next_col = col + 1'b1;
				next_beat = beat + 1'b1;
				if (!burst_full && beat + 1'b1 == burst_len)
				begin
					next_state = sdcmd_pkg::SDCMD_IDLE;
					if (ap)
						next_bank_open[cur_bank] = 1'b0;
					next_ap = 1'b0;
				end
			end
			case (cmd)
				sdcmd_pkg::SDCMD_ACT:
				begin
					next_bank_open[ba] = 1'b1;
					next_open_row[ba] = a;
				end
				sdcmd_pkg::SDCMD_RD, sdcmd_pkg::SDCMD_WR:
				begin
					next_state = (cmd == sdcmd_pkg::SDCMD_RD) ?
						sdcmd_pkg::SDCMD_BURST_RD : sdcmd_pkg::SDCMD_BURST_WR;
					next_cur_bank = ba;
					next_col = a[7:0];
					next_beat = '0;
					next_ap = a[sdcmd_pkg::AP_BIT];
				end
				sdcmd_pkg::SDCMD_BST:
				begin
					next_state = sdcmd_pkg::SDCMD_IDLE;
					if (ap)
						next_bank_open[cur_bank] = 1'b0;
					next_ap = 1'b0;
				end
				sdcmd_pkg::SDCMD_PRE:
				begin
					if (a[sdcmd_pkg::AP_BIT])
						next_bank_open = 4'h0;
					else
						next_bank_open[ba] = 1'b0;
				end
				sdcmd_pkg::SDCMD_REF:
				begin
					if (cke)
					begin
						next_refresh_row = refresh_row + 1'b1;
						next_refresh_pulse = 1'b1;
					end
					else
					begin
						next_state = sdcmd_pkg::SDCMD_SELFREF;
						next_self_refresh = 1'b1;
						next_sr_cnt = '0;
					end
				end
				sdcmd_pkg::SDCMD_MRS:
					next_mode_reg = a;
				default:
					next_ap = next_ap;
			endcase
		end
	end

	// Read mask pipe: high-Z follows mask by two clocks
	always_comb
	begin
		next_mask_d1 = dqm;
		next_rd_en_pipe = {rd_en_pipe[2:0], state == sdcmd_pkg::SDCMD_BURST_RD};
	end

	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			state <= sdcmd_pkg::SDCMD_IDLE;
			bank_open <= 4'h0;
			for (int i = 0; i < 4; i++)
				open_row[i] <= 12'h000;
			mode_reg <= sdcmd_pkg::MODE_RESET;
			refresh_row <= sdcmd_pkg::REFRESH_ROW_RESET;
			col <= 8'h00;
			cur_bank <= 2'h0;
			ap <= 1'b0;
			beat <= 4'h0;
			sr_cnt <= '0;
			refresh_pulse <= 1'b0;
			self_refresh <= 1'b0;
			mask_d1 <= 4'hF;
			rd_en_pipe <= 4'h0;
		end
		else
		begin
			state <= next_state;
			bank_open <= next_bank_open;
			open_row <= next_open_row;
			mode_reg <= next_mode_reg;
			refresh_row <= next_refresh_row;
			col <= next_col;
			cur_bank <= next_cur_bank;
			ap <= next_ap;
			beat <= next_beat;
			sr_cnt <= next_sr_cnt;
			refresh_pulse <= next_refresh_pulse;
			self_refresh <= next_self_refresh;
			mask_d1 <= next_mask_d1;
			rd_en_pipe <= next_rd_en_pipe;
		end
	end

	// ==========================================
	// Data paths
	// Write entry: bank, row, column, lane enables, data
	logic [57:0] wr_word;
	assign wr_word = {cur_bank, open_row[cur_bank], col, ~dqm, dqi};

	sdcmd_fifo #(
		.WIDTH(58),
		.DEPTH(sdcmd_pkg::FIFO_DEPTH)
	) u_wr_fifo (
		.clk(clk),
		.sys_rst(sys_rst),
		.in_valid(wr_push),
		.in_ready(fifo_in_ready),
		.in_data(wr_word),
		.out_valid(arr_wr_valid),
		.out_ready(arr_wr_ready),
		.out_data(arr_wr_data)
	);

	// A full FIFO loses beats; stall flag tells the array side to drain
	always_ff @(posedge clk or posedge sys_rst)
	begin
		if (sys_rst)
		begin
			wr_stall <= 1'b0;
			dq_out <= 32'h0000_0000;
			dq_oe <= 4'h0;
			arr_rd_row <= 12'h000;
			arr_rd_col <= 8'h00;
			arr_rd_bank <= 2'h0;
		end
		else
		begin
			wr_stall <= !fifo_in_ready;
			arr_rd_row <= open_row[cur_bank];
			arr_rd_col <= col;
			arr_rd_bank <= cur_bank;
			dq_out <= arr_rd_data;
			for (int l = 0; l < 4; l++)
				dq_oe[l] <= rd_en_pipe[0] && !mask_d1[l];
		end
	end

	// ==========================================
	// Checks
	a_pre_all_closes: assert property (@(posedge clk) disable iff (sys_rst)
		cmd == sdcmd_pkg::SDCMD_PRE && a[10] && state != sdcmd_pkg::SDCMD_SELFREF
		|=> bank_open == 4'h0)
		else $error("precharge all left a bank open");
	a_act_opens_bank: assert property (@(posedge clk) disable iff (sys_rst)
		cmd == sdcmd_pkg::SDCMD_ACT && state != sdcmd_pkg::SDCMD_SELFREF
		|=> bank_open[$past(ba)])
		else $error("activate did not open bank");
	a_mode_load_op: assert property (@(posedge clk) disable iff (sys_rst)
		cmd == sdcmd_pkg::SDCMD_MRS && state != sdcmd_pkg::SDCMD_SELFREF
		|=> mode_reg == $past(a))
		else $error("mode load opcode not taken");
	a_deselect_holds: assert property (@(posedge clk) disable iff (sys_rst)
		cs_n && state == sdcmd_pkg::SDCMD_IDLE |=> mode_reg == $past(mode_reg)
		&& bank_open == $past(bank_open))
		else $error("deselected device changed state");
	a_selfref_entry: assert property (@(posedge clk) disable iff (sys_rst)
		cmd == sdcmd_pkg::SDCMD_REF && !cke && state == sdcmd_pkg::SDCMD_IDLE
		|=> self_refresh ##0 !cke [*2] |-> self_refresh)
		else $error("self refresh not entered");
	a_selfref_ignores: assert property (@(posedge clk) disable iff (sys_rst)
		state == sdcmd_pkg::SDCMD_SELFREF && !cke |=> $stable(bank_open)
		&& $stable(mode_reg))
		else $error("input acted in self refresh");
	a_auto_refresh_row: assert property (@(posedge clk) disable iff (sys_rst)
		cmd == sdcmd_pkg::SDCMD_REF && cke && state != sdcmd_pkg::SDCMD_SELFREF
		|=> refresh_row == $past(refresh_row) + 12'h001)
		else $error("refresh row not advanced");
	a_read_mask_lat: assert property (@(posedge clk) disable iff (sys_rst)
		dqm[0] |-> ##2 !dq_oe[0])
		else $error("masked read lane driven");
	a_ap_oneshot: assert property (@(posedge clk) disable iff (sys_rst)
		(cmd == sdcmd_pkg::SDCMD_RD || cmd == sdcmd_pkg::SDCMD_WR)
		&& state != sdcmd_pkg::SDCMD_SELFREF |=> ap == $past(a[10]))
		else $error("auto precharge flag wrong");
	a_bst_stops: assert property (@(posedge clk) disable iff (sys_rst)
		cmd == sdcmd_pkg::SDCMD_BST && state != sdcmd_pkg::SDCMD_SELFREF
		|=> state == sdcmd_pkg::SDCMD_IDLE)
		else $error("burst not terminated");
	c_read_burst: cover property (@(posedge clk) state == sdcmd_pkg::SDCMD_BURST_RD);
	c_write_push: cover property (@(posedge clk) wr_push);
	c_self_refresh: cover property (@(posedge clk) self_refresh ##1 !self_refresh);
	c_fifo_full: cover property (@(posedge clk) wr_stall);
endmodule
`default_nettype wire

// *** tb/sdcmd_ctl_model.sv ***
// Controller model driving the command pins of the SDRAM device
`timescale 1ns/10ps
`default_nettype none
module sdcmd_ctl_model #(
	parameter int PRE_CYC = 1,
	parameter int ROW_ACTIVE_MIN_CYC = 4
) (
	// Clock
	input wire logic clk,
	// Command pins
	output logic chip_sel_n,
	output logic row_strobe_n,
	output logic col_strobe_n,
	output logic write_strobe_n,
	output logic clk_gate,
	output logic [1:0] bank_sel,
	output logic [11:0] addr,
	// Data pins
	output logic [3:0] data_mask,
	output logic [31:0] dq_in
);
	// =========================================================
	// Idle pins
	initial
	begin
		chip_sel_n = 1'b1;
		{row_strobe_n, col_strobe_n, write_strobe_n} = 3'h7;
		clk_gate = 1'b1;
		bank_sel = 2'h0;
		addr = 12'h000;
		data_mask = 4'h0;
		dq_in = 32'h00000000;
	end

	// =========================================================
	// Commands
	// One command for one clock, then no-ops; changes land after the edge
	task automatic issue(input logic cs_n, input logic [2:0] rcw,
		input logic [1:0] ba, input logic [11:0] a, input int gap,
		input logic gate = 1'b1);
		@(posedge clk);
		#1;
		chip_sel_n = cs_n;
		{row_strobe_n, col_strobe_n, write_strobe_n} = rcw;
		clk_gate = gate;
		bank_sel = ba;
		addr = a;
		@(posedge clk);
		#1;
		chip_sel_n = 1'b0;
		{row_strobe_n, col_strobe_n, write_strobe_n} = 3'h7;
		// Released lines must not keep a stale but plausible value
		bank_sel = ~ba;
		addr = ~a;
		repeat (gap) @(posedge clk);
		// Hand back just past the edge so callers never race the design
		if (gap > 0)
			#1;
	endtask

	task automatic set_lanes(input logic [3:0] m, input logic [31:0] d);
		@(posedge clk);
		#1;
		data_mask = m;
		dq_in = d;
	endtask

	// Mode load: banks idle, then the load delay in no-ops
	task automatic mode_load(input logic [11:0] op);
		issue(1'b0, 3'h0, 2'h0, op, 2);
	endtask

	// Precharge one bank or all, then let the precharge period pass
	task automatic precharge(input logic [1:0] ba, input logic all_banks);
		issue(1'b0, 3'h2, ba, all_banks ? 12'h400 : 12'h000, PRE_CYC);
	endtask

	// Clock gate stays low for the whole stay, kept at least the minimum
	task automatic sr_enter();
		issue(1'b0, 3'h1, 2'h0, 12'h000, ROW_ACTIVE_MIN_CYC, 1'b0);
	endtask

	// Clock already runs; raise the gate, then no-ops for the exit delay
	task automatic sr_exit();
		@(posedge clk);
		#1;
		clk_gate = 1'b1;
		repeat (sdcmd_pkg::SR_EXIT_CLKS + 1) @(posedge clk);
		#1;
	endtask
endmodule
`default_nettype wire

// *** tb/sdram_command_interface_tb.sv ***
// Self-checking testbench of the SDRAM command interface
`timescale 1ns/10ps
`default_nettype none
module sdram_command_interface_tb;
	localparam logic [2:0] cmd_act = 3'h3;
	localparam logic [2:0] cmd_rd = 3'h5;
	localparam logic [2:0] cmd_wr = 3'h4;
	localparam logic [2:0] cmd_bst = 3'h6;
	localparam logic [2:0] cmd_pre = 3'h2;
	localparam logic [2:0] cmd_ref = 3'h1;
	logic clk = 1'b0;
	logic sys_rst = 1'b1;
	logic arr_wr_ready = 1'b1;
	logic [31:0] arr_rd_data = 32'hA5A5A5A5;
	logic chip_sel_n, row_strobe_n, col_strobe_n, write_strobe_n, clk_gate;
	logic [1:0] bank_sel, arr_rd_bank;
	logic [11:0] addr, arr_rd_row, mode_reg, refresh_row;
	logic [3:0] data_mask, dq_oe, bank_open;
	logic [31:0] dq_in, dq_out;
	logic [57:0] arr_wr_data;
	logic [7:0] arr_rd_col;
	logic arr_wr_valid, self_refresh, refresh_pulse, wr_stall;
	int failures = 0;
	int comparisons = 0;
	int i;

	always #10 clk = ~clk;

	// =========================================================
	// Instances
	sdcmd_ctl_model i_ctl (.clk(clk), .chip_sel_n(chip_sel_n),
		.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
		.write_strobe_n(write_strobe_n), .clk_gate(clk_gate),
		.bank_sel(bank_sel), .addr(addr), .data_mask(data_mask),
		.dq_in(dq_in));
	sdcmd_core i_dut (.clk(clk), .sys_rst(sys_rst), .chip_sel_n(chip_sel_n),
		.row_strobe_n(row_strobe_n), .col_strobe_n(col_strobe_n),
		.write_strobe_n(write_strobe_n), .clk_gate(clk_gate),
		.bank_sel(bank_sel), .addr(addr), .data_mask(data_mask),
		.dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
		.arr_wr_valid(arr_wr_valid), .arr_wr_ready(arr_wr_ready),
		.arr_wr_data(arr_wr_data), .arr_rd_data(arr_rd_data),
		.arr_rd_row(arr_rd_row), .arr_rd_col(arr_rd_col),
		.arr_rd_bank(arr_rd_bank), .bank_open(bank_open),
		.mode_reg(mode_reg), .refresh_row(refresh_row),
		.self_refresh(self_refresh), .refresh_pulse(refresh_pulse),
		.wr_stall(wr_stall));

	// =========================================================
	// Shared tasks
	task automatic check(input logic [55:0] seen, input logic [55:0] exp,
		input string what);
		comparisons++;
		if (seen !== exp)
		begin
			failures++;
			$display("ERROR at %0t: %s seen %h expected %h", $time, what,
				seen, exp);
		end
	endtask

	task automatic results();
		$display("Counts: %0d comparisons, %0d failures", comparisons,
			failures);
		if (failures == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic hung(input string what);
		failures++;
		$display("ERROR at %0t: no %s in time", $time, what);
		results();
	endtask

	// Settle after the sync stages; inputs move 1 ns past the edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// =========================================================
	// Scenarios
	task automatic t_banks();
		i_ctl.mode_load(12'h2A3);
		cyc(4);
		check(56'(mode_reg), 56'h2A3, "mode");
		i_ctl.issue(1'b0, cmd_act, 2'h2, 12'h0F0, 1);
		cyc(4);
		check(56'(bank_open), 56'h4, "open");
		i_ctl.issue(1'b1, cmd_act, 2'h1, 12'h00F, 1);
		cyc(4);
		check(56'(bank_open), 56'h4, "deselected");
		i_ctl.issue(1'b0, cmd_pre, 2'h2, 12'h000, 1);
		cyc(4);
		check(56'(bank_open), 56'h0, "one bank");
		for (i = 0; i < 4; i++)
			if (i != 2)
				i_ctl.issue(1'b0, cmd_act, 2'(i), 12'h111, 1);
		cyc(4);
		check(56'(bank_open), 56'hB, "three open");
		i_ctl.issue(1'b0, cmd_pre, 2'h2, 12'h400, 1);
		cyc(4);
		check(56'(bank_open), 56'h0, "all closed");
		$display("Test banks done");
	endtask

	task automatic t_read();
		i_ctl.issue(1'b0, cmd_act, 2'h0, 12'h020, 1);
		i_ctl.issue(1'b0, cmd_act, 2'h1, 12'h030, 1);
		i_ctl.set_lanes(4'h5, 32'h00000000);
		i_ctl.issue(1'b0, cmd_rd, 2'h0, 12'h420, 0);
		for (i = 0; i < 12 && dq_oe === 4'h0; i++)
			cyc(1);
		if (i == 12)
			hung("read lanes");
		check(56'(dq_oe), 56'hA, "lanes");
		check(56'(dq_out), 56'hA5A5A5A5, "read data");
		cyc(14);
		check(56'(bank_open), 56'h2, "auto close");
		i_ctl.issue(1'b0, cmd_rd, 2'h1, 12'h020, 14);
		cyc(1);
		check(56'(bank_open), 56'h2, "kept open");
		check(56'({arr_rd_bank, arr_rd_row}), 56'h1030, "rd addr");
		i_ctl.set_lanes(4'h0, 32'h00000000);
		i_ctl.precharge(2'h1, 1'b0);
		$display("Test read done");
	endtask

	task automatic t_fifo();
		int n;
		n = 0;
		i_ctl.mode_load(12'h007);
		i_ctl.issue(1'b0, cmd_act, 2'h3, 12'h055, 1);
		arr_wr_ready = 1'b0;
		i_ctl.set_lanes(4'h3, 32'h12345678);
		i_ctl.issue(1'b0, cmd_wr, 2'h3, 12'h010, 0);
		for (i = 0; i < 40 && wr_stall !== 1'b1; i++)
			cyc(1);
		if (i == 40)
			hung("write stall");
		i_ctl.issue(1'b0, cmd_bst, 2'h0, 12'h000, 4);
		cyc(1);
		check(56'(arr_wr_data[35:0]), 56'hC12345678, "lane data");
		check(56'(arr_wr_data[57:36]), 56'h305510, "wr addr");
		arr_wr_ready = 1'b1;
		repeat (40)
		begin
			if (arr_wr_valid === 1'b1)
				n++;
			cyc(1);
		end
		check(56'(n), 56'(sdcmd_pkg::FIFO_DEPTH), "drained");
		check(56'(wr_stall), 56'h0, "stall");
		i_ctl.set_lanes(4'h0, 32'h00000000);
		i_ctl.issue(1'b0, cmd_pre, 2'h0, 12'h400, 1);
		$display("Test fifo done");
	endtask

	task automatic t_refresh();
		logic [11:0] r0;
		r0 = refresh_row;
		i_ctl.issue(1'b0, cmd_ref, 2'h3, 12'hFFF, 0);
		for (i = 0; i < 8 && refresh_pulse !== 1'b1; i++)
			cyc(1);
		if (i == 8)
			hung("refresh");
		check(56'(self_refresh), 56'h0, "auto");
		cyc(2);
		check(56'(refresh_row), 56'(r0 + 12'h001), "row");
		i_ctl.sr_enter();
		check(56'(self_refresh), 56'h1, "enter");
		i_ctl.issue(1'b0, cmd_act, 2'h0, 12'h001, 4, 1'b0);
		check(56'(bank_open), 56'h0, "ignored");
		i_ctl.sr_exit();
		for (i = 0; i < 8 && self_refresh !== 1'b0; i++)
			cyc(1);
		check(56'(self_refresh), 56'h0, "exit");
		i_ctl.issue(1'b0, cmd_ref, 2'h0, 12'h000, 0);
		for (i = 0; i < 8 && refresh_pulse !== 1'b1; i++)
			cyc(1);
		check(56'(refresh_pulse), 56'h1, "resume");
		$display("Test refresh done");
	endtask

	// =========================================================
	// Main sequence
	initial
	begin
		cyc(20);
		sys_rst = 1'b0;
		cyc(2);
		check(56'(bank_open), 56'h0, "reset open");
		check(56'(dq_oe), 56'h0, "reset lanes");
		t_banks();
		t_read();
		t_fifo();
		t_refresh();
		results();
	end
endmodule
`default_nettype wire
